// file: design/sadc_pkg.sv
/*
 Shared constants and types for the serial converter readout link.
 Assumes a 50 MHz system clock on both ends.
*/
`default_nettype none
package sadc_pkg;
	localparam int RESULT_W       = 16;
	localparam int SHIFT_W        = RESULT_W + 1;
	localparam int FIFO_DEPTH     = 8;
	localparam int SYNC_STAGES    = 3;
	localparam int CLK_PERIOD_NS  = 20;
	// Times in ns, or in tenths of ns where printed with a fraction
	localparam int T_CONV_MIN_NS  = 500;
	localparam int T_CONV_MAX_NS  = 930;
	localparam int T_ACQ_NS       = 540;
	localparam int T_CYCLE_NS     = 1470;
	localparam int T_STROBE_LO_NS = 20;
	localparam int T_SEL_SU_DNS   = 75;
	localparam int T_CLK_SU_NS    = 5;
	localparam int T_DO_EN_DNS    = 123;
	localparam int T_DO_HZ_DNS    = 132;
	// Longest times round down, least times round up, never below one cycle
	localparam int CONV_CYC      = T_CONV_MAX_NS / CLK_PERIOD_NS;
	localparam int ACQ_CYC       = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYCLE_CYC     = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_LO_CYC = (T_STROBE_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SEL_SU_CYC    = (T_SEL_SU_DNS + 10 * CLK_PERIOD_NS - 1) / (10 * CLK_PERIOD_NS);
	localparam int CLK_SU_CYC    = (T_CLK_SU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DO_EN_CYC     = (T_DO_EN_DNS / (10 * CLK_PERIOD_NS) < 1) ? 1
		: T_DO_EN_DNS / (10 * CLK_PERIOD_NS);
	localparam int DO_HZ_CYC     = (T_DO_HZ_DNS / (10 * CLK_PERIOD_NS) < 1) ? 1
		: T_DO_HZ_DNS / (10 * CLK_PERIOD_NS);
	// Pin synchroniser latency that the host must leave room for
	localparam int SYNC_MARGIN   = 6;
	localparam int SCLK_HALF     = 8;
	// Reset levels of synchronised pins {sclk, serial_in, strobe}
	localparam logic [2:0] PIN_RST = 3'h3;
	typedef enum logic [1:0] {
		DEV_IDLE  = 2'h0,
		DEV_CONV  = 2'h1,
		DEV_READY = 2'h3
	} sadc_dev_state_t;
	typedef enum logic [2:0] {
		HST_IDLE  = 3'h0,
		HST_PULSE = 3'h1,
		HST_CONV  = 3'h3,
		HST_SEL   = 3'h2,
		HST_SHIFT = 3'h6,
		HST_END   = 3'h7,
		HST_ACQ   = 3'h5
	} sadc_hst_state_t;
endpackage : sadc_pkg
`default_nettype wire

// file: design/sadc_if.sv
/*
 Pin-level link between the converter end and its host.
 A released serial output reads as the inverse of the last bit, so a
 host that samples before the enable sees wrong data.
*/
`timescale 1ns/100ps
`default_nettype none
interface sadc_if;
	logic convert_strobe;
	logic serial_in;
	logic serial_clk;
	logic serial_out;
	logic serial_out_oe;
	wire  serial_out_wire;
	assign serial_out_wire = serial_out_oe ? serial_out : ~serial_out;
	modport device (
		input  convert_strobe,
		input  serial_in,
		input  serial_clk,
		output serial_out,
		output serial_out_oe
	);
	modport host (
		output convert_strobe,
		output serial_in,
		output serial_clk,
		input  serial_out_wire
	);
endinterface : sadc_if
`default_nettype wire

// file: design/sadc_fifo.sv
/*
 Parameterised synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module sadc_fifo #(
	parameter int WIDTH = sadc_pkg::RESULT_W,
	parameter int DEPTH = sadc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	// Fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Drain side
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	import sadc_pkg::*;
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic             push;
	logic             pop;

	assign o_in_ready  = (count_ff != FULL_CNT);
	assign o_out_valid = (count_ff != '0);
	assign o_out_data  = mem[rd_ptr_ff];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_ff @(posedge i_clock)
	begin
		if (push)
			mem[wr_ptr_ff] <= i_in_data;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;
			if (push && !pop)
				count_ff <= count_ff + 1'b1;
			else if (pop && !push)
				count_ff <= count_ff - 1'b1;
		end
	end
endmodule : sadc_fifo
`default_nettype wire

// file: design/sadc_device.sv
/*
 Converter end of the serial readout link: mode choice at conversion
 start, conversion timing, three-state serial output, daisy-chain shift.
 Assumes the link pins are asynchronous to i_clock; the conversion
 result arrives on i_result from the analog core.
*/
`timescale 1ns/100ps
`default_nettype none
module sadc_device #(
	parameter int CONV_CYCLES = sadc_pkg::CONV_CYC
) (
	// Clock and reset
	input  wire logic                          i_clock,
	input  wire logic                          i_rst_n,
	// Link pins
	sadc_if.device                             link,
	// Converter core and wiring straps
	input  wire logic [sadc_pkg::RESULT_W-1:0] i_result,
	input  wire logic                          i_four_wire,
	input  wire logic                          i_busy_en,
	// Status
	output logic                               o_result_take,
	output logic                               o_daisy,
	output logic                               o_converting
);
	import sadc_pkg::*;
	localparam int CW = $clog2(CONV_CYCLES + 1);
	localparam logic [CW-1:0] CONV_LOAD = (CW)'(CONV_CYCLES - 1);
	localparam logic [4:0] BITS_PLAIN = 5'(RESULT_W);
	localparam logic [4:0] BITS_BUSY  = 5'(SHIFT_W);

	// Pin synchronisers: {sclk, serial_in, strobe}
	logic [2:0] pins;
	logic [2:0] s1_ff;
	logic [2:0] s2_ff;
	logic [2:0] s3_ff;
	logic [2:0] lvl_ff;
	logic [2:0] prev_ff;
	logic [2:0] agree;
	logic [2:0] rise;
	logic [2:0] fall;
	logic       strobe;
	logic       din;

	sadc_dev_state_t  state_ff;
	logic [CW-1:0]    conv_cnt_ff;
	logic [SHIFT_W-1:0] shift_ff;
	logic [4:0]       bits_ff;
	logic             daisy_ff;
	logic             drive_ff;
	logic             done_ff;
	logic             cs_act;
	logic             cs_prev_ff;
	logic             take_ff;

	assign pins  = {link.serial_clk, link.serial_in, link.convert_strobe};
	assign agree = ~(s2_ff ^ s3_ff);
	assign rise  = lvl_ff & ~prev_ff;
	assign fall  = ~lvl_ff & prev_ff;
	assign strobe = lvl_ff[0];
	assign din    = lvl_ff[1];

	// A level change counts once the second and third stages agree
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			s1_ff   <= PIN_RST;
			s2_ff   <= PIN_RST;
			s3_ff   <= PIN_RST;
			lvl_ff  <= PIN_RST;
			prev_ff <= PIN_RST;
		end
		else
		begin
			s1_ff   <= pins;
			s2_ff   <= s1_ff;
			s3_ff   <= s2_ff;
			lvl_ff  <= (lvl_ff & ~agree) | (s3_ff & agree);
			prev_ff <= lvl_ff;
		end
	end

	// Chip select per wiring; daisy chain also uses the strobe
	always_comb
	begin
		if (!daisy_ff && i_four_wire)
			cs_act = ~din;
		else
			cs_act = ~strobe;
	end

	// Conversion sequencing, runs regardless of the strobe level
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			state_ff    <= DEV_IDLE;
			conv_cnt_ff <= '0;
			daisy_ff    <= 1'b0;
			take_ff     <= 1'b0;
		end
		else
		begin
			take_ff <= 1'b0;
			if (rise[0])
			begin
				state_ff    <= DEV_CONV;
				conv_cnt_ff <= CONV_LOAD;
				daisy_ff    <= ~din;
			end
			else
			begin
				unique case (state_ff)
					DEV_IDLE:
						state_ff <= DEV_IDLE;
					DEV_CONV:
					begin
						if (conv_cnt_ff == '0)
						begin
							state_ff <= DEV_READY;
							take_ff  <= 1'b1;
						end
						else
							conv_cnt_ff <= conv_cnt_ff - 1'b1;
					end
					DEV_READY:
						state_ff <= DEV_READY;
					default:
						state_ff <= DEV_IDLE;
				endcase
			end
		end
	end

	// Readout shifter; the serial clock moves data and, unless daisy_ff is set, drops the enable after the last bit, never state_ff
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			shift_ff   <= '0;
			bits_ff    <= '0;
			drive_ff   <= 1'b0;
			done_ff    <= 1'b0;
			cs_prev_ff <= 1'b0;
		end
		else
		begin
			cs_prev_ff <= cs_act;
			if (rise[0])
			begin
				// A new conversion start forces the output off
				drive_ff <= 1'b0;
				done_ff  <= 1'b0;
			end
			else if (take_ff)
			begin
				if (i_busy_en)
				begin
					shift_ff <= {1'b1, i_result};
					bits_ff  <= BITS_BUSY;
				end
				else
				begin
					shift_ff <= {i_result, 1'b0};
					bits_ff  <= BITS_PLAIN;
				end
				drive_ff <= cs_act;
			end
			else if (state_ff == DEV_READY)
			begin
				if (!cs_act)
					drive_ff <= 1'b0;
				else if (cs_act && !cs_prev_ff && !done_ff)
					drive_ff <= 1'b1;
				else if (drive_ff && fall[2])
				begin
					// Daisy chain: upstream bit sampled on the same fall
					shift_ff <= {shift_ff[SHIFT_W-2:0], daisy_ff & din};
					if (!daisy_ff)
					begin
						bits_ff <= bits_ff - 1'b1;
						if (bits_ff == 5'h1)
						begin
							drive_ff <= 1'b0;
							done_ff  <= 1'b1;
						end
					end
				end
			end
		end
	end

	// Output bit lags one stage behind the shifter top
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			link.serial_out    <= 1'b0;
			link.serial_out_oe <= 1'b0;
		end
		else
		begin
			link.serial_out    <= shift_ff[SHIFT_W-1];
			link.serial_out_oe <= drive_ff;
		end
	end

	assign o_result_take = take_ff;
	assign o_daisy       = daisy_ff;
	assign o_converting  = (state_ff == DEV_CONV);
endmodule : sadc_device
`default_nettype wire

// file: design/sadc_host.sv
/*
 Host end of the serial readout link: starts conversions, selects the
 chosen wiring, makes the serial clock by division and queues results.
 Assumes the serial output wire is asynchronous to i_clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sadc_host #(
	parameter int HALF_CYCLES = sadc_pkg::SCLK_HALF,
	parameter int DEPTH       = sadc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                          i_clock,
	input  wire logic                          i_rst_n,
	// Link pins
	sadc_if.host                               link,
	// Command
	input  wire logic                          i_start,
	input  wire logic                          i_daisy,
	input  wire logic                          i_four_wire,
	input  wire logic                          i_busy_en,
	output logic                               o_busy,
	// Result stream
	output logic                               o_valid,
	output logic [sadc_pkg::RESULT_W-1:0]      o_data,
	input  wire logic                          i_ready
);
	import sadc_pkg::*;
	localparam logic [7:0] PULSE_LOAD = 8'(STROBE_LO_CYC + SEL_SU_CYC + SYNC_MARGIN - 1);
	localparam logic [7:0] CONV_LOAD  = 8'(CONV_CYC + SYNC_MARGIN + CLK_SU_CYC);
	localparam logic [7:0] SEL_LOAD   = 8'(2 * SYNC_MARGIN);
	localparam logic [7:0] HALF_LOAD  = 8'(HALF_CYCLES - 1);
	localparam logic [7:0] ACQ_LOAD   = 8'(CYCLE_CYC - 1);

	sadc_hst_state_t  state_ff;
	logic [7:0]       cnt_ff;
	logic [4:0]       bits_ff;
	logic [SHIFT_W-1:0] cap_ff;
	logic             strobe_ff;
	logic             sdi_ff;
	logic             sclk_ff;
	logic             daisy_ff;
	logic             four_ff;
	logic             busy_ind_ff;
	logic             push_ff;
	logic             fifo_ready;
	logic             s1_ff;
	logic             s2_ff;
	logic             s3_ff;
	logic             sdo_ff;

	// Serial data resynchronised; change counts once stages two and three agree
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			s1_ff  <= 1'b0;
			s2_ff  <= 1'b0;
			s3_ff  <= 1'b0;
			sdo_ff <= 1'b0;
		end
		else
		begin
			s1_ff <= link.serial_out_wire;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff)
				sdo_ff <= s3_ff;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			state_ff    <= HST_IDLE;
			cnt_ff      <= '0;
			bits_ff     <= '0;
			cap_ff      <= '0;
			strobe_ff   <= 1'b1;
			sdi_ff      <= 1'b1;
			sclk_ff     <= 1'b0;
			daisy_ff    <= 1'b0;
			four_ff     <= 1'b0;
			busy_ind_ff <= 1'b0;
			push_ff     <= 1'b0;
		end
		else
		begin
			push_ff <= 1'b0;
			if (cnt_ff != '0)
				cnt_ff <= cnt_ff - 1'b1;
			unique case (state_ff)
				HST_IDLE:
				begin
					// No start while the queue cannot take the result
					if (i_start && fifo_ready)
					begin
						state_ff    <= HST_PULSE;
						cnt_ff      <= PULSE_LOAD;
						strobe_ff   <= 1'b0;
						sdi_ff      <= ~i_daisy;
						daisy_ff    <= i_daisy;
						four_ff     <= i_four_wire;
						busy_ind_ff <= i_busy_en;
					end
				end
				HST_PULSE:
					if (cnt_ff == '0)
					begin
						state_ff  <= HST_CONV;
						cnt_ff    <= CONV_LOAD;
						strobe_ff <= 1'b1;
					end
				HST_CONV:
					// Mode level and clock held until the device has seen the edge
					if (cnt_ff == '0)
					begin
						state_ff <= HST_SEL;
						cnt_ff   <= SEL_LOAD;
						if (four_ff && !daisy_ff)
							sdi_ff <= 1'b0;
						else
						begin
							strobe_ff <= 1'b0;
							sdi_ff    <= ~daisy_ff;
						end
					end
				HST_SEL:
					if (cnt_ff == '0)
					begin
						state_ff <= HST_SHIFT;
						cnt_ff   <= HALF_LOAD;
						bits_ff  <= busy_ind_ff ? 5'(SHIFT_W) : 5'(RESULT_W);
					end
				HST_SHIFT:
					if (cnt_ff == '0)
					begin
						cnt_ff <= HALF_LOAD;
						if (!sclk_ff)
							sclk_ff <= 1'b1;
						else
						begin
							// Sample late in the high phase, then fall
							cap_ff  <= {cap_ff[SHIFT_W-2:0], sdo_ff};
							sclk_ff <= 1'b0;
							bits_ff <= bits_ff - 1'b1;
							if (bits_ff == 5'h1)
								state_ff <= HST_END;
						end
					end
				HST_END:
					if (cnt_ff == '0)
					begin
						state_ff  <= HST_ACQ;
						cnt_ff    <= ACQ_LOAD;
						strobe_ff <= 1'b1;
						sdi_ff    <= 1'b1;
						push_ff   <= 1'b1;
					end
				HST_ACQ:
					if (cnt_ff == '0)
						state_ff <= HST_IDLE;
				default:
					state_ff <= HST_IDLE;
			endcase
		end
	end

	sadc_fifo #(
		.WIDTH (RESULT_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.i_clock     (i_clock),
		.i_rst_n     (i_rst_n),
		.i_in_valid  (push_ff),
		.i_in_data   (cap_ff[RESULT_W-1:0]),
		.o_in_ready  (fifo_ready),
		.o_out_valid (o_valid),
		.o_out_data  (o_data),
		.i_out_ready (i_ready)
	);

	assign link.convert_strobe = strobe_ff;
	assign link.serial_in      = sdi_ff;
	assign link.serial_clk     = sclk_ff;
	assign o_busy              = (state_ff != HST_IDLE);
endmodule : sadc_host
`default_nettype wire

// file: tb/sadc_monitor.sv
/*
 Pin-level checker for the readout link between host and converter.
 Assumes it is instantiated beside the link interface, single clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sadc_monitor (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	// Link pins
	input  wire logic convert_strobe,
	input  wire logic serial_in,
	input  wire logic serial_clk,
	input  wire logic serial_out,
	input  wire logic serial_out_oe
);
	import sadc_pkg::*;
	logic [4:0] low_cnt_ff;
	logic [7:0] since_start_ff;
	logic [4:0] since_fall_ff;
	logic       short_rise;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// Short low pulses start conversions; long lows are reads
	assign short_rise = convert_strobe && low_cnt_ff != 5'h0 && low_cnt_ff < 5'h14;
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n || convert_strobe)
			low_cnt_ff <= 5'h0;
		else if (low_cnt_ff != 5'h1f)
			low_cnt_ff <= low_cnt_ff + 5'h1;
	end
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			since_start_ff <= 8'hff;
		else if (short_rise)
			since_start_ff <= 8'h0;
		else if (since_start_ff != 8'hff)
			since_start_ff <= since_start_ff + 8'h1;
	end
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			since_fall_ff <= 5'h1f;
		else if ($fell(serial_clk))
			since_fall_ff <= 5'h0;
		else if (since_fall_ff != 5'h1f)
			since_fall_ff <= since_fall_ff + 5'h1;
	end
	sequence s_deselect;
		$rose(convert_strobe) ##0 serial_in;
	endsequence
	sequence s_released;
		!serial_out_oe [*2];
	endsequence
	a_oe_quiet: assert property ((convert_strobe && serial_in) [*8] |-> !serial_out_oe)
		else $error("serial output driven while deselected");
	a_sel_setup: assert property (short_rise |-> $stable(serial_in) && $past(serial_in, 4) == serial_in)
		else $error("mode level not steady before start");
	a_sclk_steady: assert property (short_rise |-> !serial_clk && !$past(serial_clk) ##1 !serial_clk)
		else $error("serial clock moved around start");
	a_strobe_low: assert property ($fell(convert_strobe) |=> !convert_strobe [*2])
		else $error("strobe low pulse too short");
	a_start_space: assert property (short_rise |-> since_start_ff >= 8'(CYCLE_CYC - 1))
		else $error("conversion starts too close");
	a_sclk_idle: assert property (since_start_ff < 8'h30 |-> !serial_clk)
		else $error("serial clock during conversion");
	a_shift_on_fall: assert property (serial_out_oe && $past(serial_out_oe)
		&& $changed(serial_out) |-> since_fall_ff <= 5'h8)
		else $error("output bit moved without clock fall");
	a_enable_4w: assert property ($fell(serial_in) && convert_strobe |-> ##[1:8] serial_out_oe)
		else $error("no output after select fell");
	a_release_sel: assert property (s_deselect |-> ##[1:8] s_released)
		else $error("output not released on strobe rise");
	a_release_4w: assert property ($rose(serial_in) && convert_strobe |-> ##[1:8] s_released)
		else $error("output not released on select rise");
endmodule : sadc_monitor
`default_nettype wire

// file: tb/sadc_tb.sv
/*
 Self-checking bench: host and converter ends joined by one link.
 Assumes the design package; checker sits beside the link.
*/
`timescale 1ns/100ps
`default_nettype none
module sadc_tb;
	import sadc_pkg::*;
	typedef struct packed {
		logic                daisy;
		logic                four;
		logic                busy;
		logic [RESULT_W-1:0] result;
		logic [RESULT_W-1:0] exp_data;
	} sadc_row_t;
	logic                i_clock;
	logic                i_rst_n;
	logic                i_start;
	logic                i_daisy;
	logic                i_four_wire;
	logic                i_busy_en;
	logic                i_ready;
	logic [RESULT_W-1:0] i_result;
	logic                o_busy;
	logic                o_valid;
	logic [RESULT_W-1:0] o_data;
	logic                o_daisy;
	logic                o_result_take;
	logic                o_converting;
	logic                conv_ok;
	int                  conv_n;
	int                  fails;
	int                  num_checks;
	int                  cycles;
	int                  n;
	sadc_row_t           rows [6];
	sadc_if sadc_if_i ();
	sadc_host sadc_host_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .link(sadc_if_i),
		.i_start(i_start), .i_daisy(i_daisy), .i_four_wire(i_four_wire), .i_busy_en(i_busy_en),
		.o_busy(o_busy), .o_valid(o_valid), .o_data(o_data), .i_ready(i_ready));
	sadc_device sadc_device_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .link(sadc_if_i),
		.i_result(i_result), .i_four_wire(i_four_wire), .i_busy_en(i_busy_en),
		.o_result_take(o_result_take), .o_daisy(o_daisy), .o_converting(o_converting));
	sadc_monitor sadc_monitor_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.convert_strobe(sadc_if_i.convert_strobe), .serial_in(sadc_if_i.serial_in),
		.serial_clk(sadc_if_i.serial_clk), .serial_out(sadc_if_i.serial_out),
		.serial_out_oe(sadc_if_i.serial_out_oe));
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task automatic wait_idle();
		for (n = 0; n < 3000 && o_busy !== 1'b0; n++)
			@(negedge i_clock);
		check("idle", 16'(o_busy), 16'h0);
	endtask : wait_idle
	task automatic pin_rest();
		check("strobe", 16'(sadc_if_i.convert_strobe), 16'h1);
		check("out_oe", 16'(sadc_if_i.serial_out_oe), 16'h0);
		check("sclk", 16'(sadc_if_i.serial_clk), 16'h0);
		check("busy", 16'(o_busy), 16'h0);
		check("valid", 16'(o_valid), 16'h0);
		check("converting", 16'(o_converting), 16'h0);
		check("take_rest", 16'(o_result_take), 16'h0);
	endtask : pin_rest
	// One conversion and read; the word is popped at once
	task automatic run_row(input sadc_row_t r);
		wait_idle();
		i_daisy = r.daisy;
		i_four_wire = r.four;
		i_busy_en = r.busy;
		i_result = r.result;
		i_start = 1'b1;
		@(negedge i_clock);
		i_start = 1'b0;
		for (n = 0; n < 40 && o_converting !== 1'b1; n++)
			@(negedge i_clock);
		for (conv_n = 0; conv_n < 100 && o_converting === 1'b1; conv_n++)
			@(negedge i_clock);
		// Length judged against the allowed window, not the design's count
		conv_ok = (conv_n * CLK_PERIOD_NS >= T_CONV_MIN_NS);
		conv_ok = conv_ok && (conv_n * CLK_PERIOD_NS <= T_CONV_MAX_NS);
		check("conv_time", 16'(conv_ok), 16'h1);
		check("take", 16'(o_result_take), 16'h1);
		for (n = 0; n < 3000 && o_valid !== 1'b1; n++)
			@(negedge i_clock);
		check("got_word", 16'(o_valid), 16'h1);
		check("data", o_data, r.exp_data);
		check("daisy_mode", 16'(o_daisy), 16'(r.daisy));
		i_ready = 1'b1;
		@(negedge i_clock);
		i_ready = 1'b0;
	endtask : run_row
	initial
	begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end
	always @(posedge i_clock)
	begin
		cycles++;
		// Rows take about 430 cycles each; far above the whole run
		if (cycles == 40000)
		begin
			fails++;
			stop_test();
		end
	end
	initial
	begin
		{i_rst_n, i_start, i_daisy, i_four_wire, i_busy_en, i_ready} = 6'h0;
		i_result = 16'h0;
		fails = 0;
		num_checks = 0;
		cycles = 0;
		rows[0] = '{1'b0, 1'b0, 1'b0, 16'h8001, 16'h8001};
		rows[1] = '{1'b0, 1'b0, 1'b1, 16'hffff, 16'hffff};
		rows[2] = '{1'b0, 1'b1, 1'b0, 16'h0000, 16'h0000};
		rows[3] = '{1'b0, 1'b1, 1'b1, 16'ha5a5, 16'ha5a5};
		rows[4] = '{1'b1, 1'b0, 1'b0, 16'h7ffe, 16'h7ffe};
		rows[5] = '{1'b1, 1'b0, 1'b1, 16'h1234, 16'h1234};
		repeat (15) @(negedge i_clock);
		pin_rest();
		@(negedge i_clock);
		i_rst_n = 1'b1;
		repeat (2) @(negedge i_clock);
		foreach (rows[k])
			run_row(rows[k]);
		// Fill without draining: ninth start must be refused
		i_four_wire = 1'b1;
		i_busy_en = 1'b0;
		i_daisy = 1'b0;
		for (int k = 0; k < 9; k++)
		begin
			wait_idle();
			i_result = 16'h0100 + 16'(k);
			i_start = 1'b1;
			@(negedge i_clock);
			i_start = 1'b0;
			check("accept", 16'(o_busy), 16'(k < 8));
		end
		for (int k = 0; k < 8; k++)
		begin
			check("fifo_valid", 16'(o_valid), 16'h1);
			check("fifo_data", o_data, 16'h0100 + 16'(k));
			i_ready = 1'b1;
			@(negedge i_clock);
			i_ready = 1'b0;
		end
		check("fifo_empty", 16'(o_valid), 16'h0);
		// Reset in the middle of a shift
		wait_idle();
		i_result = 16'h5a5a;
		i_start = 1'b1;
		@(negedge i_clock);
		i_start = 1'b0;
		repeat (100) @(negedge i_clock);
		i_rst_n = 1'b0;
		repeat (2) @(negedge i_clock);
		pin_rest();
		i_rst_n = 1'b1;
		repeat (2) @(negedge i_clock);
		run_row(rows[3]);
		run_row(rows[5]);
		stop_test();
	end
endmodule : sadc_tb
`default_nettype wire
